// ===== recirc_defs.svh
// constants for the motor recirculation counter: offsets, fields, resets, timing
`ifndef RECIRC_DEFS_SVH
`define RECIRC_DEFS_SVH

// register byte addresses
`define RC_COUNT_OFS      32'h0000_0000
`define RC_CTRL_OFS       32'h0000_0004
`define RC_STATUS_OFS     32'h0000_0008

// widths
`define RC_COUNT_W        8
`define RC_PRESC_W        6

// prescaler terminal value: bus clock divided by 64
`define RC_PRESC_LAST     6'h3F
`define RC_PRESC_ZERO     6'h00

// counter values
`define RC_COUNT_ZERO     8'h00
`define RC_COUNT_ONE      8'h01
`define RC_COUNT_STEP     8'h01

// control register field and reset
`define RC_CTRL_EN_BIT    0
`define RC_CTRL_RESET     1'h1

// status register fields
`define RC_STAT_SENSE_BIT 0
`define RC_STAT_WAIT_BIT  1

// axi responses
`define RC_RESP_OKAY      2'h0
`define RC_RESP_SLVERR    2'h2
`define RC_RESP_DECERR    2'h3

`define RC_DATA_ZERO      32'h0000_0000

`endif

// ===== recirc_pkg.sv
// types shared by the motor recirculation counter
`default_nettype none

package recirc_pkg;

  // which register an address selects
  typedef enum logic [1:0] {
    SEL_COUNT,
    SEL_CTRL,
    SEL_STATUS,
    SEL_NONE
  } reg_sel_t;

  // one read answer, held until rready
  typedef struct packed {
    logic [31:0] data;
    logic [1:0]  resp;
  } rd_answer_t;

  // control word, software visible
  typedef struct packed {
    logic count_en;
  } ctrl_t;

endpackage

`default_nettype wire

// ===== motor_recirculation_counter.sv
// integrating counter of sense-pin high time with an axi4-lite register slave
//
// Behaviour
// - 8-bit counter, tick every 64 bus clocks
// - increment per tick only while pin high
// - count readable, read-only, writes ignored
// - each count read outside wait state clears count after returning it
// - counting continues during processor wait state
// - no count read or clear in wait
//
// Chosen here: the AXI4-Lite register port and the address map.
`include "recirc_defs.svh"
`default_nettype none

module motor_recirculation_counter (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // motor sense pin, asynchronous to aclk
  input  wire logic        recirculation_sense_pin,
  // processor wait state, from logic on aclk
  input  wire logic        cpu_wait,
  // axi4-lite write address
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] awaddr,
  input  wire logic [2:0]  awprot,
  // axi4-lite write data
  input  wire logic        wvalid,
  output var  logic        wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  // axi4-lite write response
  output var  logic        bvalid,
  input  wire logic        bready,
  output var  logic [1:0]  bresp,
  // axi4-lite read address
  input  wire logic        arvalid,
  output var  logic        arready,
  input  wire logic [31:0] araddr,
  input  wire logic [2:0]  arprot,
  // axi4-lite read data
  output var  logic        rvalid,
  input  wire logic        rready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp
);

  ////////////////////////////////////////////////////////////////////////////////
  // state

  logic                      sense_meta_q;
  logic                      sense_q;
  logic [`RC_PRESC_W-1:0]    presc_q;
  logic                      tick_q;
  logic [`RC_COUNT_W-1:0]    count_q;
  logic [`RC_COUNT_W-1:0]    count_d;
  recirc_pkg::ctrl_t         ctrl_q;
  logic                      awready_q;
  logic                      wready_q;
  logic                      bvalid_q;
  logic [1:0]                bresp_q;
  logic                      arready_q;
  logic                      rvalid_q;
  recirc_pkg::rd_answer_t    rd_q;
  recirc_pkg::rd_answer_t    rd_d;
  logic                      wr_fire;
  logic                      rd_fire;
  logic                      count_clear;
  logic                      count_inc;
  recirc_pkg::reg_sel_t      wr_sel;
  recirc_pkg::reg_sel_t      rd_sel;

  function automatic recirc_pkg::reg_sel_t decode(input logic [31:0] addr);
    case (addr)
      `RC_COUNT_OFS:  decode = recirc_pkg::SEL_COUNT;
      `RC_CTRL_OFS:   decode = recirc_pkg::SEL_CTRL;
      `RC_STATUS_OFS: decode = recirc_pkg::SEL_STATUS;
      default:        decode = recirc_pkg::SEL_NONE;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // sense pin synchroniser

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sense_meta_q <= 1'b0;
      sense_q      <= 1'b0;
    end else begin
      sense_meta_q <= recirculation_sense_pin;
      sense_q      <= sense_meta_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // divide-by-64 prescaler; free running, wait state does not stop it

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_q <= `RC_PRESC_ZERO;
      tick_q  <= 1'b0;
    end else begin
      presc_q <= presc_q + `RC_PRESC_W'(1);
      tick_q  <= (presc_q == `RC_PRESC_LAST);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // counter

  assign wr_sel = decode(awaddr);
  assign rd_sel = decode(araddr);

  // handshakes complete on the cycle ready is shown high with valid
  assign wr_fire = awready_q && awvalid && wready_q && wvalid;
  assign rd_fire = arready_q && arvalid;

  // a read in wait state is refused, so it never clears
  assign count_clear = rd_fire && (rd_sel == recirc_pkg::SEL_COUNT) && !cpu_wait;
  assign count_inc   = tick_q && sense_q && ctrl_q.count_en;

  always_comb begin
    count_d = count_q;
    if (count_clear && count_inc) begin
      // a tick landing on the clearing read is kept, not lost
      count_d = `RC_COUNT_ONE;
    end else if (count_clear) begin
      count_d = `RC_COUNT_ZERO;
    end else if (count_inc) begin
      count_d = count_q + `RC_COUNT_STEP;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= `RC_COUNT_ZERO;
    end else begin
      count_q <= count_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // write channel: aw and w are taken together once both are offered

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
    end else if (!awready_q && awvalid && wvalid && !bvalid_q) begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
    end else begin
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q.count_en <= `RC_CTRL_RESET;
    end else if (wr_fire && (wr_sel == recirc_pkg::SEL_CTRL) && wstrb[0]) begin
      ctrl_q.count_en <= wdata[`RC_CTRL_EN_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `RC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      case (wr_sel)
        // count and status ignore writes but accept them
        recirc_pkg::SEL_COUNT:  bresp_q <= `RC_RESP_OKAY;
        recirc_pkg::SEL_CTRL:   bresp_q <= `RC_RESP_OKAY;
        recirc_pkg::SEL_STATUS: bresp_q <= `RC_RESP_OKAY;
        default:                bresp_q <= `RC_RESP_DECERR;
      endcase
    end else if (bvalid_q && bready) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read channel

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
    end else begin
      arready_q <= !arready_q && arvalid && !rvalid_q;
    end
  end

  always_comb begin
    rd_d.data = `RC_DATA_ZERO;
    rd_d.resp = `RC_RESP_OKAY;
    case (rd_sel)
      recirc_pkg::SEL_COUNT: begin
        if (cpu_wait) begin
          rd_d.resp = `RC_RESP_SLVERR;
        end else begin
          // value returned is the one before the clear
          rd_d.data[`RC_COUNT_W-1:0] = count_q;
        end
      end
      recirc_pkg::SEL_CTRL: begin
        rd_d.data[`RC_CTRL_EN_BIT] = ctrl_q.count_en;
      end
      recirc_pkg::SEL_STATUS: begin
        rd_d.data[`RC_STAT_SENSE_BIT] = sense_q;
        rd_d.data[`RC_STAT_WAIT_BIT]  = cpu_wait;
      end
      default: begin
        rd_d.resp = `RC_RESP_DECERR;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q  <= 1'b0;
      rd_q.data <= `RC_DATA_ZERO;
      rd_q.resp <= `RC_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rd_q     <= rd_d;
    end else if (rvalid_q && rready) begin
      rvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs

  assign awready = awready_q;
  assign wready  = wready_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;
  assign arready = arready_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rd_q.data;
  assign rresp   = rd_q.resp;

endmodule

`default_nettype wire

// ===== motor_recirculation_counter_properties.sv
// port-level assertions for the recirculation counter
`include "recirc_defs.svh"
`default_nettype none
module motor_recirculation_counter_properties (
  // clock, reset and processor wait state
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        cpu_wait,
  // write side
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] awaddr,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [1:0]  bresp,
  // read side
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] araddr,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  aw_w_pair_a: assert property (awready |-> wready)
    else $error("address taken without data");
  wr_answer_a: assert property (awvalid && awready |=> bvalid)
    else $error("write response late");
  wr_unmapped_a: assert property (awvalid && awready && awaddr == 32'h0000_000C
    |=> bresp == `RC_RESP_DECERR) else $error("unmapped write not refused");
  ar_prompt_a: assert property (arvalid && !arready && !rvalid |=> arready)
    else $error("read address not taken");
  rd_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data changed before taken");
  wr_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");
  rd_width_a: assert property (rvalid |-> rdata[31:8] == 24'h00_0000)
    else $error("count wider than eight bits");
  wait_refuse_a: assert property (arvalid && arready && cpu_wait && araddr == `RC_COUNT_OFS
    |=> rresp == `RC_RESP_SLVERR && rdata == `RC_DATA_ZERO) else $error("count read in wait");
  rd_okay_a: assert property (arvalid && arready && !cpu_wait && araddr == `RC_COUNT_OFS
    |=> rresp == `RC_RESP_OKAY) else $error("count read refused");
endmodule
bind motor_recirculation_counter motor_recirculation_counter_properties u_props (.aclk,
  .aresetn, .cpu_wait, .awvalid, .awready, .awaddr, .wready, .bvalid, .bready, .bresp, .arvalid,
  .arready, .araddr, .rvalid, .rready, .rdata, .rresp);
`default_nettype wire

// ===== recirc_sense_model.sv
// sense pin source: holds the pin high for a set number of clock edges
`default_nettype none
module recirc_sense_model (
  // clock
  input  wire logic        aclk,
  // request
  input  wire logic        start,
  input  wire logic [15:0] len,
  // pin, push-pull so low between pulses
  output var  logic        pin = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] left_q = 16'h0000;
  // pin is an input on the device side, the model owns the level
  always @(posedge aclk) begin
    if (start) begin
      pin <= 1'b1;
      left_q <= len;
    end else if (left_q > 16'h0001) begin
      left_q <= left_q - 16'h0001;
    end else begin
      pin <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== motor_recirculation_counter_tb.sv
// self-checking bench for the recirculation counter
`include "recirc_defs.svh"
`default_nettype none
module motor_recirculation_counter_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'b0, aresetn = 1'b0, cpu_wait = 1'b0, sense, start = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic [15:0] len = 16'h0000;
  int checks = 0, miscompares = 0, cycles = 0;
  always #20 aclk = ~aclk;
  motor_recirculation_counter u_motor_recirculation_counter (.aclk, .aresetn,
    .recirculation_sense_pin(sense), .cpu_wait, .awvalid, .awready, .awaddr,
    .awprot(3'h0), .wvalid, .wready, .wdata, .wstrb(4'hF), .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .arprot(3'h0), .rvalid, .rready, .rdata, .rresp);
  recirc_sense_model u_recirc_sense_model (.aclk, .start, .len, .pin(sense));
  task automatic chk(input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wrc(input logic [31:0] a, d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    // response left waiting one cycle so its hold is exercised
    bready <= 1'b1;
    @(posedge aclk);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rdc(input logic [31:0] a, e, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    // data left waiting one cycle so its hold is exercised
    rready <= 1'b1;
    @(posedge aclk);
    rready <= 1'b0;
    chk(rdata, e);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic pulse(input logic [15:0] l);
    @(posedge aclk);
    start <= 1'b1; len <= l;
    @(posedge aclk);
    start <= 1'b0;
  endtask
  task automatic final_report;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // a hang is cut short well past the longest run
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      final_report;
    end
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(`RC_COUNT_OFS, `RC_DATA_ZERO, `RC_RESP_OKAY);
    wrc(`RC_COUNT_OFS, 32'h0000_00FF, `RC_RESP_OKAY);
    rdc(`RC_COUNT_OFS, `RC_DATA_ZERO, `RC_RESP_OKAY);
    wrc(32'h0000_000C, `RC_DATA_ZERO, `RC_RESP_DECERR);
    rdc(32'h0000_000C, `RC_DATA_ZERO, `RC_RESP_DECERR);
    $display("test registers done");
    wrc(`RC_CTRL_OFS, `RC_DATA_ZERO, `RC_RESP_OKAY);
    rdc(`RC_CTRL_OFS, `RC_DATA_ZERO, `RC_RESP_OKAY);
    wrc(`RC_STATUS_OFS, 32'h0000_00FF, `RC_RESP_OKAY);
    // one tick period of pin high with counting switched off
    pulse(16'h0040);
    cpu_wait <= 1'b1;
    rdc(`RC_STATUS_OFS, 32'h0000_0003, `RC_RESP_OKAY);
    cpu_wait <= 1'b0;
    repeat (80) @(posedge aclk);
    rdc(`RC_STATUS_OFS, `RC_DATA_ZERO, `RC_RESP_OKAY);
    rdc(`RC_COUNT_OFS, `RC_DATA_ZERO, `RC_RESP_OKAY);
    wrc(`RC_CTRL_OFS, 32'h0000_0001, `RC_RESP_OKAY);
    rdc(`RC_CTRL_OFS, 32'h0000_0001, `RC_RESP_OKAY);
    $display("test control done");
    // window of 320 edges holds exactly five ticks
    pulse(16'h0140);
    cpu_wait <= 1'b1;
    rdc(`RC_COUNT_OFS, `RC_DATA_ZERO, `RC_RESP_SLVERR);
    repeat (250) @(posedge aclk);
    cpu_wait <= 1'b0;
    repeat (100) @(posedge aclk);
    rdc(`RC_COUNT_OFS, 32'h0000_0005, `RC_RESP_OKAY);
    rdc(`RC_COUNT_OFS, `RC_DATA_ZERO, `RC_RESP_OKAY);
    $display("test wait done");
    pulse(16'h4080);
    repeat (16'h4092) @(posedge aclk);
    rdc(`RC_COUNT_OFS, 32'h0000_0002, `RC_RESP_OKAY);
    $display("test wrap done");
    final_report;
  end
endmodule
`default_nettype wire
